//--- pkg/floppy_support_pkg.sv
package floppy_support_pkg;

    // ------------------------------------------------------------------
    // timing base
    // ------------------------------------------------------------------
    localparam int MCLK_MHZ    = 16;
    localparam int NS_PER_US   = 1000;
    localparam int CNT_W       = 6;
    localparam int IN_W        = 13;

    localparam int WCK_PULSE_NS     = 250;
    localparam int WCK_PERIOD_HI_NS = 1000;
    localparam int WCK_PERIOD_LO_NS = 2000;
    localparam int RDD_PULSE_NS     = 250;
    localparam int RDW_CYCLE_NS     = 2000;
    localparam int RDW_RESYNC_NS    = 875;
    localparam int DMA_DELAY_NS     = 1000;
    localparam int PRECOMP_EARLY_NS = 150;
    localparam int PRECOMP_NOM_NS   = 275;
    localparam int PRECOMP_LATE_NS  = 400;
    localparam int WRD_PULSE_NS     = 125;

    // least times: round up to whole master ticks, never below one
    function automatic logic [CNT_W-1:0] ns_to_ticks(input int ns);
        int t;
        t = (ns * MCLK_MHZ + NS_PER_US - 1) / NS_PER_US;
        if (t < 1) begin
            t = 1;
        end
        return t[CNT_W-1:0];
    endfunction

    localparam logic [CNT_W-1:0] WCK_PULSE_T  = ns_to_ticks(WCK_PULSE_NS);
    localparam logic [CNT_W-1:0] WCK_HI_T     = ns_to_ticks(WCK_PERIOD_HI_NS);
    localparam logic [CNT_W-1:0] WCK_LO_T     = ns_to_ticks(WCK_PERIOD_LO_NS);
    localparam logic [CNT_W-1:0] RDD_T        = ns_to_ticks(RDD_PULSE_NS);
    localparam logic [CNT_W-1:0] RDW_HALF_T   = ns_to_ticks(RDW_CYCLE_NS / 2);
    localparam logic [CNT_W-1:0] RDW_RESYNC_T = ns_to_ticks(RDW_RESYNC_NS);
    localparam logic [CNT_W-1:0] DMA_T        = ns_to_ticks(DMA_DELAY_NS);
    localparam logic [CNT_W-1:0] EARLY_T      = ns_to_ticks(PRECOMP_EARLY_NS);
    localparam logic [CNT_W-1:0] NOM_T        = ns_to_ticks(PRECOMP_NOM_NS);
    localparam logic [CNT_W-1:0] LATE_T       = ns_to_ticks(PRECOMP_LATE_NS);
    localparam logic [CNT_W-1:0] WRD_T        = ns_to_ticks(WRD_PULSE_NS);
    localparam logic [CNT_W-1:0] CNT_ONE      = 6'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO     = 6'h00;

    // ------------------------------------------------------------------
    // precompensation select {sel_1, sel_0}
    // ------------------------------------------------------------------
    localparam logic [1:0] PC_NOMINAL = 2'h0;
    localparam logic [1:0] PC_EARLY   = 2'h1;
    localparam logic [1:0] PC_LATE    = 2'h2;

    typedef enum logic [1:0] {
        WR_IDLE  = 2'b00,
        WR_DELAY = 2'b01,
        WR_PULSE = 2'b10
    } wr_state_t;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CLEAR  = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_ENABLE = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_LEVELS = 8'h0c;

    localparam int EV_W    = 4;
    localparam int EV_STEP = 0;
    localparam int EV_TRK  = 1;
    localparam int EV_DMA  = 2;
    localparam int EV_IRQ  = 3;
    localparam int LV_W    = 5;

    localparam logic [EV_W-1:0]   EV_RESET   = 4'h0;
    localparam logic [DATA_W-1:0] DATA_ZERO  = 32'h00000000;

endpackage

//--- design/floppy_sync2.sv
`timescale 1ns/1ps
module floppy_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    // ------------------------------------------------------------------
    // two-stage synchroniser, first stage feeds only the second
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t q;
    sync_state_t d;

    always_comb begin
        d        = q;
        d.meta   = async_i;
        d.stable = q.meta;
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sync_o = q.stable;
endmodule

//--- design/floppy_support_logic.sv
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// R1: controller clock is master clock /2 when density high, /4 when low
// R2: write clock gives 250 ns pulses, period 1 us high density, 2 us low
// R3: density input 0 means low density drive, 1 high; sets the controller and write clock rates
// R4: falling drive read stream gives a 250 ns separated read pulse
// R5: read window toggles each 1 us, resynced so pulses sit inside a phase
// R6: each step request becomes an active-low step output toward the drive
// R7: seek mode high enables step and track zero; low enables read/write (code gates only the write path; the read separator runs in both modes)
// R8: active-low drive track zero is passed to the controller
// R9: serial write data goes to the drive active low while write gate is on
// R10: precomp select shifts each written pulse early, nominal or late
// R11: dma request out asserts after request high about 1 us, drops at once
// R12: dma request and interrupt pass only while the gate input is high
// R13: all generated timing counts edges of the 16 MHz master clock
module floppy_support_logic
    import floppy_support_pkg::*;
(
    input  wire logic              clock_i,
    input  wire logic              rst_n_i,
    input  wire logic              master_clk_16_i,
    input  wire logic              density_sel_i,
    input  wire logic              drive_read_stream_n_i,
    input  wire logic              step_request_in_i,
    input  wire logic              seek_mode_i,
    input  wire logic              drive_track_zero_n_i,
    input  wire logic              write_gate_in_i,
    input  wire logic              ctrl_write_stream_i,
    input  wire logic              precomp_sel_0_i,
    input  wire logic              precomp_sel_1_i,
    input  wire logic              ctrl_dma_req_i,
    input  wire logic              dma_irq_gate_i,
    input  wire logic              ctrl_irq_in_i,
    output logic                   controller_clk_out_o,
    output logic                   write_clk_out_o,
    output logic                   separated_read_pulse_o,
    output logic                   read_window_o,
    output logic                   step_n_o,
    output logic                   ctrl_track_zero_o,
    output logic                   drive_write_stream_n_o,
    output logic                   delayed_dma_req_n_o,
    output logic                   gated_irq_out_o,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [DATA_W-1:0] pwdata_i,
    output logic      [DATA_W-1:0] prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    output logic                   event_irq_o
);
    // ------------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------------
    logic [IN_W-1:0] sync_w;
    logic            m16_s;
    logic            density_s;
    logic            rd_n_s;
    logic            step_s;
    logic            seek_s;
    logic            trk_n_s;
    logic            wgate_s;
    logic            wdata_s;
    logic            ps0_s;
    logic            ps1_s;
    logic            dma_s;
    logic            gate_s;
    logic            irq_s;

    floppy_sync2 #(
        .WIDTH (IN_W)
    ) u_sync (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .async_i ({master_clk_16_i, density_sel_i, drive_read_stream_n_i,
                   step_request_in_i, seek_mode_i, drive_track_zero_n_i,
                   write_gate_in_i, ctrl_write_stream_i, precomp_sel_0_i,
                   precomp_sel_1_i, ctrl_dma_req_i, dma_irq_gate_i,
                   ctrl_irq_in_i}),
        .sync_o  (sync_w)
    );

    assign {m16_s, density_s, rd_n_s, step_s, seek_s, trk_n_s, wgate_s,
            wdata_s, ps0_s, ps1_s, dma_s, gate_s, irq_s} = sync_w;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              m16_prev;
        logic              fdc_phase;
        logic              fdc_clk;
        logic [CNT_W-1:0]  wck_cnt;
        logic              write_clk_out;
        logic              rd_prev;
        logic              rd_pend;
        logic [CNT_W-1:0]  rd_cnt;
        logic              separated_read_pulse;
        logic [CNT_W-1:0]  win_cnt;
        logic              win;
        logic              wr_prev;
        wr_state_t         wr_state;
        logic [CNT_W-1:0]  wr_cnt;
        logic              wr_n;
        logic [CNT_W-1:0]  dma_cnt;
        logic              dma_n;
        logic              irq_out;
        logic              irq_prev;
        logic              step_n;
        logic              trk;
        logic [EV_W-1:0]   status;
        logic [EV_W-1:0]   enable;
        logic [DATA_W-1:0] prdata;
        logic              irq_line;
    } core_state_t;

    localparam core_state_t RESET_Q = '{
        m16_prev: 1'b0, fdc_phase: 1'b0, fdc_clk: 1'b0, wck_cnt: CNT_ZERO,
        write_clk_out: 1'b0, rd_prev: 1'b0, rd_pend: 1'b0, rd_cnt: CNT_ZERO, separated_read_pulse: 1'b0,
        win_cnt: RDW_HALF_T, win: 1'b0, wr_prev: 1'b0, wr_state: WR_IDLE,
        wr_cnt: CNT_ZERO, wr_n: 1'b1, dma_cnt: CNT_ZERO, dma_n: 1'b1,
        irq_out: 1'b0, irq_prev: 1'b0, step_n: 1'b1, trk: 1'b0,
        status: EV_RESET, enable: EV_RESET, prdata: DATA_ZERO, irq_line: 1'b0};

    core_state_t q;
    core_state_t d;

    function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
        return (a == ADDR_STATUS) || (a == ADDR_CLEAR) ||
               (a == ADDR_ENABLE) || (a == ADDR_LEVELS);
    endfunction

    logic             tick;
    logic [CNT_W-1:0] wck_last;
    logic [EV_W-1:0]  ev;
    logic [EV_W-1:0]  clr;
    logic             acc_wr;
    logic [LV_W-1:0]  levels;

    assign tick   = m16_s && !q.m16_prev;                              // [R13]
    assign acc_wr = psel_i && penable_i && pwrite_i;
    assign levels = {q.win, q.separated_read_pulse, q.trk, seek_s, density_s};

    always_comb begin
        d        = q;
        ev       = EV_RESET;
        clr      = EV_RESET;
        wck_last = (density_s ? WCK_HI_T : WCK_LO_T) - CNT_ONE;       // [R3]
        d.m16_prev = m16_s;

        // ------------------------------------------------------------------
        // clock generation
        // ------------------------------------------------------------------
        if (tick) begin
            d.fdc_phase = !q.fdc_phase;
            if (density_s || q.fdc_phase) begin                        // [R1]
                d.fdc_clk = !q.fdc_clk;
            end
            d.wck_cnt = (q.wck_cnt >= wck_last) ? CNT_ZERO : q.wck_cnt + CNT_ONE;
        end
        d.write_clk_out = (d.wck_cnt < WCK_PULSE_T);                             // [R2]

        // ------------------------------------------------------------------
        // data separator: act on ticks only so the widths are whole ticks
        // ------------------------------------------------------------------
        d.rd_prev = rd_n_s;
        if (q.rd_prev && !rd_n_s) begin
            d.rd_pend = 1'b1;
        end
        if (tick) begin
            if (q.rd_pend) begin
                d.rd_pend = 1'b0;
                d.separated_read_pulse     = 1'b1;                                      // [R4]
                d.rd_cnt  = RDD_T;
                d.win_cnt = RDW_RESYNC_T;                              // [R5]
            end else begin
                if (q.separated_read_pulse) begin
                    if (q.rd_cnt == CNT_ONE) begin
                        d.separated_read_pulse = 1'b0;
                    end
                    d.rd_cnt = q.rd_cnt - CNT_ONE;
                end
                if (q.win_cnt == CNT_ONE) begin
                    d.win     = !q.win;                                // [R5]
                    d.win_cnt = RDW_HALF_T;
                end else begin
                    d.win_cnt = q.win_cnt - CNT_ONE;
                end
            end
        end

        // ------------------------------------------------------------------
        // write path with precompensation
        // ------------------------------------------------------------------
        d.wr_prev = wdata_s;
        case (q.wr_state)
            WR_IDLE: begin
                d.wr_n = 1'b1;
                if (wdata_s && !q.wr_prev && wgate_s && !seek_s) begin // [R9]
                    d.wr_state = WR_DELAY;
                    case ({ps1_s, ps0_s})                              // [R10]
                        PC_EARLY: d.wr_cnt = EARLY_T;
                        PC_LATE:  d.wr_cnt = LATE_T;
                        default:  d.wr_cnt = NOM_T;
                    endcase
                end
            end
            WR_DELAY: begin
                if (tick) begin
                    if (q.wr_cnt == CNT_ONE) begin
                        d.wr_state = WR_PULSE;
                        d.wr_n     = 1'b0;                             // [R9]
                        d.wr_cnt   = WRD_T;
                    end else begin
                        d.wr_cnt = q.wr_cnt - CNT_ONE;
                    end
                end
            end
            WR_PULSE: begin
                if (tick) begin
                    if (q.wr_cnt == CNT_ONE) begin
                        d.wr_state = WR_IDLE;
                        d.wr_n     = 1'b1;
                    end else begin
                        d.wr_cnt = q.wr_cnt - CNT_ONE;
                    end
                end
            end
            default: begin
                d.wr_state = WR_IDLE;
                d.wr_n     = 1'b1;
            end
        endcase
        // a dropped gate or a switch to seek cuts a pulse short
        if (!wgate_s || seek_s) begin                                  // [R7]
            d.wr_state = WR_IDLE;
            d.wr_n     = 1'b1;
        end

        // ------------------------------------------------------------------
        // step, track zero, dma and interrupt
        // ------------------------------------------------------------------
        d.step_n = !(step_s && seek_s);                                // [R6] [R7]
        d.trk    = !trk_n_s && seek_s;                                 // [R8]
        if (!dma_s) begin
            d.dma_cnt = CNT_ZERO;                                      // [R11]
        end else if (tick && (q.dma_cnt != DMA_T)) begin
            d.dma_cnt = q.dma_cnt + CNT_ONE;
        end
        d.dma_n    = !(gate_s && dma_s && (d.dma_cnt == DMA_T));       // [R11] [R12]
        d.irq_out  = gate_s && irq_s;                                  // [R12]
        d.irq_prev = irq_s;

        // ------------------------------------------------------------------
        // event status and register slave
        // ------------------------------------------------------------------
        ev[EV_STEP] = q.step_n && !d.step_n;
        ev[EV_TRK]  = !q.trk && d.trk;
        ev[EV_DMA]  = q.dma_n && !d.dma_n;
        ev[EV_IRQ]  = irq_s && !q.irq_prev;
        if (acc_wr && (paddr_i == ADDR_CLEAR)) begin
            clr = pwdata_i[EV_W-1:0];
        end
        if (acc_wr && (paddr_i == ADDR_ENABLE)) begin
            d.enable = pwdata_i[EV_W-1:0];
        end
        // a new event beats a clear in the same cycle
        d.status   = (q.status & ~clr) | ev;
        d.irq_line = |(d.status & d.enable);
        if (psel_i && !penable_i) begin
            case (paddr_i)
                ADDR_STATUS: d.prdata = {{(DATA_W-EV_W){1'b0}}, q.status};
                ADDR_ENABLE: d.prdata = {{(DATA_W-EV_W){1'b0}}, q.enable};
                ADDR_LEVELS: d.prdata = {{(DATA_W-LV_W){1'b0}}, levels};
                default:     d.prdata = DATA_ZERO;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= RESET_Q;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign controller_clk_out_o   = q.fdc_clk;
    assign write_clk_out_o        = q.write_clk_out;
    assign separated_read_pulse_o = q.separated_read_pulse;
    assign read_window_o          = q.win;
    assign step_n_o               = q.step_n;
    assign ctrl_track_zero_o      = q.trk;
    assign drive_write_stream_n_o = q.wr_n;
    assign delayed_dma_req_n_o    = q.dma_n;
    assign gated_irq_out_o        = q.irq_out;
    assign prdata_o               = q.prdata;
    assign pready_o               = 1'b1;
    assign pslverr_o              = psel_i && penable_i && !reg_mapped(paddr_i);
    assign event_irq_o            = q.irq_line;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_rdd_hold;
        separated_read_pulse_o [*8];
    endsequence

    sequence s_wck_pulse;
        write_clk_out_o [*8] ##[1:8] !write_clk_out_o;
    endsequence

    property p_div2;
        @(posedge clock_i) disable iff (!rst_n_i)
        (tick && density_s) |=> (controller_clk_out_o != $past(controller_clk_out_o));
    endproperty
    a_div2: assert property (p_div2) else $error("controller clock not halved"); // [R1]

    property p_wck;
        @(posedge clock_i) disable iff (!rst_n_i)
        $rose(write_clk_out_o) |-> s_wck_pulse;
    endproperty
    a_wck: assert property (p_wck) else $error("write clock pulse width wrong"); // [R2]

    property p_rdd;
        @(posedge clock_i) disable iff (!rst_n_i)
        $rose(separated_read_pulse_o) |-> s_rdd_hold ##[1:8] !separated_read_pulse_o;
    endproperty
    a_rdd: assert property (p_rdd) else $error("read pulse width wrong"); // [R4]

    property p_step;
        @(posedge clock_i) disable iff (!rst_n_i)
        (step_s && seek_s) |=> !step_n_o;
    endproperty
    a_step: assert property (p_step) else $error("step request not passed"); // [R6]

    property p_seek_only;
        @(posedge clock_i) disable iff (!rst_n_i)
        !seek_s |=> (step_n_o && !ctrl_track_zero_o && drive_write_stream_n_o) == 1'b1
                    || !$past(seek_s, 1) && drive_write_stream_n_o == 1'b0;
    endproperty
    a_seek_only: assert property (p_seek_only) else $error("seek mode gating wrong"); // [R7]

    property p_trk;
        @(posedge clock_i) disable iff (!rst_n_i)
        (!trk_n_s && seek_s) |=> ctrl_track_zero_o;
    endproperty
    a_trk: assert property (p_trk) else $error("track zero not passed"); // [R8]

    property p_wgate;
        @(posedge clock_i) disable iff (!rst_n_i)
        !wgate_s |=> drive_write_stream_n_o;
    endproperty
    a_wgate: assert property (p_wgate) else $error("write data without gate"); // [R9]

    property p_precomp;
        @(posedge clock_i) disable iff (!rst_n_i)
        (q.wr_state == WR_IDLE && wdata_s && !q.wr_prev && wgate_s && !seek_s)
        |=> drive_write_stream_n_o [*6];
    endproperty
    a_precomp: assert property (p_precomp) else $error("write pulse not delayed"); // [R10]

    property p_dma_delay;
        @(posedge clock_i) disable iff (!rst_n_i)
        $rose(dma_s) |=> delayed_dma_req_n_o [*8];
    endproperty
    a_dma_delay: assert property (p_dma_delay) else $error("dma request too early"); // [R11]

    property p_gate;
        @(posedge clock_i) disable iff (!rst_n_i)
        (!gate_s || !dma_s) |=> (delayed_dma_req_n_o && (gated_irq_out_o == (gate_s && irq_s))
                                 || $past(irq_s) != irq_s || $past(gate_s) != gate_s);
    endproperty
    a_gate: assert property (p_gate) else $error("dma or interrupt leaked"); // [R12]
endmodule

//--- sim/fdd_partner.sv
`timescale 1ns/1ps
module fdd_partner #(
    parameter int START_CYL = 2
) (
    input  wire logic rd_go_i,
    input  wire logic step_n_i,
    input  wire logic drive_write_stream_n_i,
    output logic      master_clk_16_o,
    output logic      drive_read_stream_n_o,
    output logic      drive_track_zero_n_o,
    output int        write_count_o
);
    // ----
    // drive side
    // ----
    int cyl = START_CYL;
    initial master_clk_16_o = 1'b0;
    initial drive_read_stream_n_o = 1'b1;
    initial write_count_o = 0;
    // crystal source runs free, unrelated to the bench clock
    always #31.25 master_clk_16_o = ~master_clk_16_o;
    always @(posedge rd_go_i) begin
        drive_read_stream_n_o = 1'b0;
        #300;
        drive_read_stream_n_o = 1'b1;
    end
    // no direction pin here, so every step moves toward cylinder zero
    always @(negedge step_n_i) begin
        if (cyl > 0) begin
            cyl = cyl - 1;
        end
    end
    assign drive_track_zero_n_o = (cyl != 0);
    always @(negedge drive_write_stream_n_i) write_count_o = write_count_o + 1;
endmodule

//--- sim/tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    import floppy_support_pkg::*;
    logic              clock_i = 1'b0, rst_n_i = 1'b0, mclk, rds_n, tz_n, rd_go = 1'b0;
    logic              dens = 1'b1, step = 1'b0, seek = 1'b0, wgate = 1'b0, wdat = 1'b0;
    logic              ps0 = 1'b0, ps1 = 1'b0, dreq = 1'b0, gate = 1'b0, irq = 1'b0;
    logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, perr, err_v;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [DATA_W-1:0] pwdata = 32'h0, prdata, g_v, e_v;
    logic              cclk, wclk, rdp, rwin, step_n, drive_track_zero_n, wr_n, dma_n, girq, eirq;
    logic [DATA_W-1:0] exp_q[$], obs_q[$];
    int                bad_count = 0, n_checks = 0, n, w, wcnt;
    wire logic [9:0]   outs = {rwin, cclk, wclk, eirq, girq, dma_n, wr_n, rdp, drive_track_zero_n, step_n};

    always #12.5 clock_i = ~clock_i;
    floppy_support_logic uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .master_clk_16_i(mclk),
        .density_sel_i(dens), .drive_read_stream_n_i(rds_n), .step_request_in_i(step),
        .seek_mode_i(seek), .drive_track_zero_n_i(tz_n), .write_gate_in_i(wgate),
        .ctrl_write_stream_i(wdat), .precomp_sel_0_i(ps0), .precomp_sel_1_i(ps1),
        .ctrl_dma_req_i(dreq), .dma_irq_gate_i(gate), .ctrl_irq_in_i(irq),
        .controller_clk_out_o(cclk), .write_clk_out_o(wclk), .separated_read_pulse_o(rdp),
        .read_window_o(rwin), .step_n_o(step_n), .ctrl_track_zero_o(drive_track_zero_n),
        .drive_write_stream_n_o(wr_n), .delayed_dma_req_n_o(dma_n), .gated_irq_out_o(girq),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
        .event_irq_o(eirq));
    fdd_partner drive (.rd_go_i(rd_go), .step_n_i(step_n), .drive_write_stream_n_i(wr_n),
        .master_clk_16_o(mclk), .drive_read_stream_n_o(rds_n), .drive_track_zero_n_o(tz_n),
        .write_count_o(wcnt));

    // ----
    // scoreboard: notes first, then a completed read
    // ----
    always @(posedge clock_i) begin
        while (obs_q.size() > 0) begin
            g_v = obs_q.pop_front();
            e_v = exp_q.pop_front();
            `CHK(g_v, e_v)
        end
        if (psel && penable && pready && !pwrite) begin
            e_v = exp_q.pop_front();
            `CHK(prdata, e_v)
        end
    end

    task automatic test_done;
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic note(input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] o);
        exp_q.push_back(e);
        obs_q.push_back(o);
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clock_i);
    endtask
    task automatic waitv(input int s, input logic v, output int c);
        c = 0;
        do begin
            @(posedge clock_i);
            c++;
        end while (outs[s] !== v && c < 400);
        if (c >= 400) begin
            bad_count++;
            test_done;
        end
    endtask
    task automatic cnt(input int s, output int c);
        logic p;
        c = 0;
        p = outs[s];
        repeat (320) begin
            @(posedge clock_i);
            c += int'(outs[s] & ~p);
            p = outs[s];
        end
    endtask
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int c;
        c = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        do begin
            @(posedge clock_i);
            c++;
        end while (pready !== 1'b1 && c < 20);
        err_v = perr;
        if (c >= 20) begin
            bad_count++;
            test_done;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock_i);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, DATA_ZERO);
    endtask

    // ----
    // main sequence
    // ----
    initial begin
        void'($urandom(60010));
        tick(10);
        rst_n_i <= 1'b1;
        tick(5);
        rd(ADDR_ENABLE, DATA_ZERO);
        w = $urandom & 32'hf;
        apb(1'b1, ADDR_ENABLE, w);
        rd(ADDR_ENABLE, w);
        rd(8'h10, DATA_ZERO);
        note(1, err_v);
        for (int i = 0; i < 2; i++) begin
            dens <= (i == 0);
            tick(20);
            cnt(8, n);
            note(n >= 63 - 32 * i && n <= 65 - 32 * i, 1);
            cnt(7, n);
            note(n >= 7 - 4 * i && n <= 9 - 4 * i, 1);
            waitv(7, 1'b0, w);
            waitv(7, 1'b1, n);
            waitv(7, 1'b0, w);
            note(w >= 9 && w <= 11, 1);
        end
        apb(1'b1, ADDR_ENABLE, 32'h1);
        seek <= 1'b1;
        repeat (2) begin
            step <= 1'b1;
            waitv(0, 1'b0, n);
            note(n <= 5, 1);
            step <= 1'b0;
            waitv(0, 1'b1, n);
        end
        tick(6);
        note({drive_track_zero_n, eirq}, 2'b11);
        rd(ADDR_STATUS, 32'h3);
        apb(1'b1, ADDR_ENABLE, DATA_ZERO);
        tick(3);
        note(eirq, 0);
        seek <= 1'b0;
        tick(6);
        note(drive_track_zero_n, 0);
        step <= 1'b1;
        tick(8);
        note(step_n, 1);
        step <= 1'b0;
        apb(1'b1, ADDR_CLEAR, 32'hf);
        rd(ADDR_STATUS, DATA_ZERO);
        gate <= 1'b1;
        tick($urandom_range(1, 8));
        dreq <= 1'b1;
        waitv(4, 1'b0, n);
        note(n >= 30 && n <= 46, 1);
        dreq <= 1'b0;
        waitv(4, 1'b1, n);
        note(n <= 5, 1);
        irq <= 1'b1;
        tick(5);
        note(girq, 1);
        gate <= 1'b0;
        dreq <= 1'b1;
        tick(60);
        note({girq, dma_n}, 2'b01);
        irq <= 1'b0;
        dreq <= 1'b0;
        rd(ADDR_STATUS, 32'hc);
        rd_go <= 1'b1;
        waitv(2, 1'b1, n);
        rd_go <= 1'b0;
        note(n <= 8, 1);
        w = rwin;
        waitv(2, 1'b0, n);
        note(n >= 9 && n <= 11, 1);
        waitv(9, !w, w);
        note(n + w >= 33 && n + w <= 37, 1);
        waitv(9, !rwin, n);
        note(n >= 39 && n <= 41, 1);
        wgate <= 1'b1;
        for (int m = 0; m < 3; m++) begin
            {ps1, ps0} <= (m == 0) ? PC_EARLY : (m == 1) ? PC_NOMINAL : PC_LATE;
            tick(4);
            wdat <= 1'b1;
            waitv(3, 1'b0, n);
            note(n >= 7 + 5 * m && n <= 15 + 5 * m, 1);
            wdat <= 1'b0;
            waitv(3, 1'b1, n);
            note(n >= 4 && n <= 6, 1);
            tick(10);
        end
        wgate <= 1'b0;
        wdat <= 1'b1;
        tick(30);
        note(wcnt, 3);
        wdat <= 1'b0;
        tick(5);
        test_done;
    end
endmodule
